//--- rtl/sad_cfg.svh
// Offsets, field positions, reset values and address ranges of the decoder
`ifndef SAD_CFG_SVH
`define SAD_CFG_SVH
`define SAD_OFF_CTRL 12'h000
`define SAD_OFF_SHADOW 12'h004
`define SAD_OFF_LOWTOP 12'h008
`define SAD_OFF_WIN0 12'h00c
`define SAD_OFF_STATUS 12'h024
`define SAD_CTRL_MONO 0
`define SAD_CTRL_ISA 1
`define SAD_CTRL_GSMM 2
`define SAD_CTRL_OPEN 3
`define SAD_CTRL_TEN 4
`define SAD_CTRL_HIGH 5
`define SAD_CTRL_TSZ 6
`define SAD_CTRL_VGA 8
`define SAD_CTRL_RST 11'h000
`define SAD_SHADOW_RST 26'h0000000
`define SAD_LOWTOP_RST 16'h1000
`define SAD_WIN_RST 32'h00000fff
`define SAD_TOPSEG_UNIT 16'h0002
`define SAD_VGA_LO 36'h0000a0000
`define SAD_VGA_HI 36'h0000bffff
`define SAD_MDA_LO 36'h0000b0000
`define SAD_MDA_HI 36'h0000b7fff
`define SAD_SHD_LO 36'h0000c0000
`define SAD_SHD_HI 36'h0000fffff
`define SAD_ISA_LO 36'h000f00000
`define SAD_ISA_HI 36'h000ffffff
`define SAD_APIC0_LO 36'h0fec00000
`define SAD_APIC0_HI 36'h0fec7ffff
`define SAD_APIC1_LO 36'h0fec80000
`define SAD_APIC1_HI 36'h0fec80fff
`define SAD_APIC2_LO 36'h0fec81000
`define SAD_APIC2_HI 36'h0fec81fff
`define SAD_APIC3_LO 36'h0fec82000
`define SAD_APIC3_HI 36'h0fec82fff
`define SAD_IRQ_LO 36'h0fee00000
`define SAD_IRQ_HI 36'h0feefffff
`define SAD_HSMM_LO 36'h0feda0000
`define SAD_HSMM_HI 36'h0fedbffff
`define SAD_HSMM_DELTA 36'h0fed00000
`define SAD_MONO_IO0 16'h03b4
`define SAD_MONO_IO1 16'h03b5
`define SAD_MONO_IO2 16'h03b8
`define SAD_MONO_IO3 16'h03b9
`define SAD_MONO_IO4 16'h03ba
`define SAD_MONO_IO5 16'h03bf
`endif

//--- rtl/sad_decoder.sv
// System address decoder with APB configuration registers
`timescale 1ns/1ps
`include "sad_cfg.svh"
module sad_decoder
    import sad_pkg::*;
(
    input wire logic clk, // 125 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error on unmapped address
    input wire logic req_valid, // Request strobe
    input wire sad_addr_t req_addr, // Request address
    input wire logic req_write, // Request is a write
    input wire logic req_io, // Request is an I/O cycle
    input wire logic req_smm_code, // Processor SMM code fetch
    input wire logic req_dword, // Request is one double word
    input wire sad_src_e req_src, // Request origin
    output logic route_valid, // Decision strobe
    output sad_dest_e route_dest, // Chosen destination
    output sad_addr_t route_addr, // Address at destination
    output logic route_read_zero, // Read returns address zero
    output logic route_write_drop, // Write discarded
    output logic route_irq_msg, // Interrupt message to processor bus
    output logic target_ready_n // Target ready for message, active low
);
    logic [10:0] ctrl;
    logic [25:0] shadow;
    logic [15:0] low_memory_top;
    logic [31:0] win [0:5];
    logic [15:0] req_count;
    logic [31:0] next_prdata;
    logic next_err;
    logic hub;
    logic smm_ok;
    logic in_vga, in_mda, in_shd, in_isa, in_irq, in_hsmm, in_top_seg, below_low_top;
    logic in_ap0, in_ap1, in_ap2, in_ap3, mono_io;
    logic [15:0] top_seg_size;
    logic [15:0] top_seg_base;
    logic [3:0] seg;
    logic [1:0] attr;
    logic [5:0] win_hit;
    sad_dest_e next_dest;
    sad_addr_t next_addr;
    logic next_rz, next_wd, next_irq;

    function automatic logic sad_in(sad_addr_t a, sad_addr_t lo, sad_addr_t hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // APB access phase answers one cycle after setup
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            prdata <= next_prdata;
            pslverr <= next_err;
        end
    end

    always_comb
    begin
        next_prdata = 32'h00000000;
        next_err = 1'b0;
        if (psel && !penable)
        begin
            case (paddr)
                `SAD_OFF_CTRL: next_prdata = {21'h000000, ctrl};
                `SAD_OFF_SHADOW: next_prdata = {6'h00, shadow};
                `SAD_OFF_LOWTOP: next_prdata = {16'h0000, low_memory_top};
                `SAD_OFF_STATUS: next_prdata = {req_count, 10'h000, route_dest};
                default:
                begin
                    next_err = 1'b1;
                    for (int i = 0; i < 6; i++)
                    begin
                        if (paddr == `SAD_OFF_WIN0 + 12'(4 * i))
                        begin
                            next_prdata = win[i];
                            next_err = 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // Configuration registers, written at the completing edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= `SAD_CTRL_RST;
            shadow <= `SAD_SHADOW_RST;
            low_memory_top <= `SAD_LOWTOP_RST;
            for (int i = 0; i < 6; i++)
            begin
                win[i] <= `SAD_WIN_RST;
            end
        end
        else if (psel && penable && pready && pwrite)
        begin
            case (paddr)
                `SAD_OFF_CTRL: ctrl <= pwdata[10:0];
                `SAD_OFF_SHADOW: shadow <= pwdata[25:0];
                `SAD_OFF_LOWTOP: low_memory_top <= pwdata[15:0];
                default:
                begin
                    for (int i = 0; i < 6; i++)
                    begin
                        if (paddr == `SAD_OFF_WIN0 + 12'(4 * i))
                        begin
                            win[i] <= pwdata;
                        end
                    end
                end
            endcase
        end
    end

    // Per bridge: memory window then prefetchable window
    for (genvar g = 0; g < 6; g++)
    begin : g_win
        sad_window u_win (
            .addr(req_addr),
            .base(win[g][11:0]),
            .limit(win[g][27:16]),
            .hit(win_hit[g])
        );
    end

    assign hub = (req_src != SAD_SRC_PROC);
    assign smm_ok = ctrl[`SAD_CTRL_GSMM] && (ctrl[`SAD_CTRL_OPEN] || req_smm_code) && !hub;
    assign in_vga = sad_in(req_addr, `SAD_VGA_LO, `SAD_VGA_HI);
    assign in_mda = sad_in(req_addr, `SAD_MDA_LO, `SAD_MDA_HI);
    assign in_shd = sad_in(req_addr, `SAD_SHD_LO, `SAD_SHD_HI);
    assign in_isa = sad_in(req_addr, `SAD_ISA_LO, `SAD_ISA_HI);
    assign in_irq = sad_in(req_addr, `SAD_IRQ_LO, `SAD_IRQ_HI);
    assign in_hsmm = sad_in(req_addr, `SAD_HSMM_LO, `SAD_HSMM_HI);
    assign in_ap0 = sad_in(req_addr, `SAD_APIC0_LO, `SAD_APIC0_HI);
    assign in_ap1 = sad_in(req_addr, `SAD_APIC1_LO, `SAD_APIC1_HI);
    assign in_ap2 = sad_in(req_addr, `SAD_APIC2_LO, `SAD_APIC2_HI);
    assign in_ap3 = sad_in(req_addr, `SAD_APIC3_LO, `SAD_APIC3_HI);
    // Size in 64 KB units: 2, 4, 8 or 16
    assign top_seg_size = `SAD_TOPSEG_UNIT << ctrl[`SAD_CTRL_TSZ +: 2];
    assign top_seg_base = low_memory_top - top_seg_size;
    assign below_low_top = (req_addr[35:32] == 4'h0) && (req_addr[31:16] < low_memory_top);
    assign in_top_seg = below_low_top && (req_addr[31:16] >= top_seg_base);
    assign mono_io = (req_addr[15:0] == `SAD_MONO_IO0) || (req_addr[15:0] == `SAD_MONO_IO1)
        || (req_addr[15:0] == `SAD_MONO_IO2) || (req_addr[15:0] == `SAD_MONO_IO3)
        || (req_addr[15:0] == `SAD_MONO_IO4) || (req_addr[15:0] == `SAD_MONO_IO5);
    // Segments 0..11 cover C0000-EFFFF, segment 12 the system BIOS
    assign seg = (req_addr[19:16] == 4'hf) ? 4'hc : req_addr[17:14];
    assign attr = shadow[{seg, 1'b0} +: 2];

    // Priority chain yields exactly one destination
    always_comb
    begin
        next_dest = SAD_DEST_LEGACY;
        next_addr = req_addr;
        next_rz = 1'b0;
        next_wd = 1'b0;
        next_irq = 1'b0;
        if (req_io)
        begin
            // Mono ports go to the enabled VGA bridge when MONO is clear; all other I/O defaults to legacy port
            if (mono_io && !ctrl[`SAD_CTRL_MONO])
            begin
                if (ctrl[`SAD_CTRL_VGA])
                    next_dest = SAD_DEST_B;
                else if (ctrl[`SAD_CTRL_VGA + 1])
                    next_dest = SAD_DEST_C;
                else if (ctrl[`SAD_CTRL_VGA + 2])
                    next_dest = SAD_DEST_D;
            end
        end
        else if (in_hsmm && ctrl[`SAD_CTRL_GSMM] && ctrl[`SAD_CTRL_HIGH])
        begin
            if (hub)
            begin
                next_dest = SAD_DEST_MEM;
                next_addr = 36'h000000000;
                next_rz = !req_write;
                next_wd = req_write;
            end
            else if (smm_ok)
            begin
                next_dest = SAD_DEST_MEM;
                next_addr = req_addr - `SAD_HSMM_DELTA;
            end
        end
        else if (in_top_seg && ctrl[`SAD_CTRL_GSMM] && ctrl[`SAD_CTRL_TEN])
        begin
            next_dest = SAD_DEST_MEM;
            if (!smm_ok)
            begin
                // Unqualified or hub access is terminated without effect
                next_addr = 36'h000000000;
                next_rz = !req_write;
                next_wd = req_write;
            end
        end
        else if (in_vga)
        begin
            if (smm_ok)
                next_dest = SAD_DEST_MEM;
            else if (in_mda && ctrl[`SAD_CTRL_MONO])
                next_dest = SAD_DEST_LEGACY;
            else if (ctrl[`SAD_CTRL_VGA])
                next_dest = SAD_DEST_B;
            else if (ctrl[`SAD_CTRL_VGA + 1])
                next_dest = SAD_DEST_C;
            else if (ctrl[`SAD_CTRL_VGA + 2])
                next_dest = SAD_DEST_D;
            else
                next_dest = SAD_DEST_LEGACY;
        end
        else if (in_shd)
        begin
            if (hub)
                next_dest = SAD_DEST_MEM;
            else if (req_write ? attr[1] : attr[0])
                next_dest = SAD_DEST_MEM;
        end
        else if (in_isa && ctrl[`SAD_CTRL_ISA])
            next_dest = SAD_DEST_LEGACY;
        else if (in_irq)
        begin
            next_dest = SAD_DEST_PROC;
            next_irq = hub && req_write && req_dword;
        end
        else if (!hub && in_ap0)
            next_dest = SAD_DEST_LEGACY;
        else if (!hub && in_ap1)
            next_dest = SAD_DEST_B;
        else if (!hub && in_ap2)
            next_dest = SAD_DEST_C;
        else if (!hub && in_ap3)
            next_dest = SAD_DEST_D;
        else if (win_hit[0] || win_hit[1])
            next_dest = SAD_DEST_B;
        else if (win_hit[2] || win_hit[3])
            next_dest = SAD_DEST_C;
        else if (win_hit[4] || win_hit[5])
            next_dest = SAD_DEST_D;
        else if (below_low_top || (req_addr[35:32] != 4'h0))
            next_dest = SAD_DEST_MEM;
        else
            next_dest = SAD_DEST_LEGACY;
    end

    // Registered decision, one cycle after the request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            route_valid <= 1'b0;
            route_dest <= SAD_DEST_LEGACY;
            route_addr <= 36'h000000000;
            route_read_zero <= 1'b0;
            route_write_drop <= 1'b0;
            route_irq_msg <= 1'b0;
            target_ready_n <= 1'b1;
        end
        else
        begin
            route_valid <= req_valid;
            route_read_zero <= req_valid && next_rz;
            route_write_drop <= req_valid && next_wd;
            route_irq_msg <= req_valid && next_irq;
            target_ready_n <= !(req_valid && next_irq);
            if (req_valid)
            begin
                route_dest <= next_dest;
                route_addr <= next_addr;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            req_count <= 16'h0000;
        else if (req_valid)
            req_count <= req_count + 16'h0001;
    end

    a_one_dest: assert property (@(posedge clk) disable iff (!rst_n)
        route_valid |-> $onehot(route_dest))
        else $error("destination not one-hot");
    a_irq_proc_bus: assert property (@(posedge clk) disable iff (!rst_n)
        route_irq_msg |-> route_dest == SAD_DEST_PROC && !target_ready_n && route_valid)
        else $error("interrupt message misrouted");
    a_hub_shadow_mem: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid && hub && !req_io && in_shd |=> route_dest == SAD_DEST_MEM)
        else $error("hub shadow access not sent to memory");
    a_apic_port: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid && !hub && !req_io && in_ap2 |=> route_dest == SAD_DEST_C)
        else $error("apic range misrouted");
    a_hub_smm_zero: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid && hub && !req_io && in_hsmm && ctrl[`SAD_CTRL_GSMM] && ctrl[`SAD_CTRL_HIGH]
        |=> route_addr == 36'h000000000 && (route_read_zero != route_write_drop))
        else $error("hub smm access not terminated");
    a_high_remap: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid && !req_io && smm_ok && in_hsmm && ctrl[`SAD_CTRL_HIGH]
        |=> route_dest == SAD_DEST_MEM && route_addr == $past(req_addr) - `SAD_HSMM_DELTA)
        else $error("high smm remap wrong");
    a_mono_legacy: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid && !req_io && in_mda && ctrl[`SAD_CTRL_MONO] && !smm_ok
        |=> route_dest == SAD_DEST_LEGACY)
        else $error("mono range not legacy");
    a_smm_video_mem: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid && !req_io && in_vga && smm_ok |=> route_dest == SAD_DEST_MEM)
        else $error("smm video access not to memory");
    a_isa_hole: assert property (@(posedge clk) disable iff (!rst_n)
        req_valid && !req_io && in_isa && ctrl[`SAD_CTRL_ISA] |=> route_dest == SAD_DEST_LEGACY)
        else $error("isa hole not legacy");
    a_apb_answer: assert property (@(posedge clk) disable iff (!rst_n)
        psel && !penable |=> pready ##1 !pready)
        else $error("apb ready timing wrong");
endmodule

//--- rtl/sad_pkg.sv
// Types shared by the address decoder
package sad_pkg;
    typedef enum logic [5:0] {
        SAD_DEST_MEM = 6'h01,
        SAD_DEST_LEGACY = 6'h02,
        SAD_DEST_B = 6'h04,
        SAD_DEST_C = 6'h08,
        SAD_DEST_D = 6'h10,
        SAD_DEST_PROC = 6'h20
    } sad_dest_e;
    typedef enum logic [2:0] {
        SAD_SRC_PROC = 3'h0,
        SAD_SRC_HUB_A = 3'h1,
        SAD_SRC_HUB_B = 3'h2,
        SAD_SRC_HUB_C = 3'h3,
        SAD_SRC_HUB_D = 3'h4
    } sad_src_e;
    typedef logic [35:0] sad_addr_t;
endpackage

//--- rtl/sad_window.sv
// Bridge memory window compare, 1 MB granularity below 4 GB
`timescale 1ns/1ps
module sad_window
    import sad_pkg::*;
(
    input wire sad_addr_t addr, // Request address
    input wire logic [11:0] base, // Window base, address bits 31:20
    input wire logic [11:0] limit, // Window limit, address bits 31:20
    output logic hit // Address inside window
);
    assign hit = (addr[35:32] == 4'h0) && (addr[31:20] >= base) && (addr[31:20] <= limit);
endmodule

//--- sim/sad_src_model.sv
// Request source standing for the processor bus and the four hub ports
`timescale 1ns/1ps
module sad_src_model
    import sad_pkg::*;
(
    input wire logic clk, // Clock
    output logic req_valid, // Request strobe
    output sad_addr_t req_addr, // Request address
    output logic req_write, // Write
    output logic req_io, // I/O cycle
    output logic req_smm_code, // SMM code fetch
    output logic req_dword, // One double word
    output sad_src_e req_src // Origin
);
    initial
    begin
        req_valid = 1'b0;
        req_addr = '0;
        {req_write, req_io, req_smm_code, req_dword} = 4'h0;
        req_src = SAD_SRC_PROC;
    end

    // Flags are write, io, code fetch, dword
    task automatic issue(input sad_addr_t a, input sad_src_e s, input logic [3:0] f);
        @(posedge clk);
        req_valid <= 1'b1;
        req_addr <= a;
        {req_write, req_io, req_smm_code, req_dword} <= f;
        req_src <= s;
    endtask

    // Released address and flag lines carry no stale value; req_src keeps its last value
    task automatic idle();
        @(posedge clk);
        req_valid <= 1'b0;
        req_addr <= ~req_addr;
        {req_write, req_io, req_smm_code, req_dword} <= ~{req_write, req_io, req_smm_code, req_dword};
    endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the address decoder
`timescale 1ns/1ps
module tb_top
    import sad_pkg::*;
;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er, rv_d;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, u, off;
    logic req_valid, req_write, req_io, req_smm_code, req_dword, route_valid;
    logic route_read_zero, route_write_drop, route_irq_msg, target_ready_n;
    sad_addr_t req_addr, route_addr, a;
    sad_src_e req_src, s;
    sad_dest_e route_dest;
    integer seed = 32'he6ba092c;
    int err_total = 0, checks_done = 0, cycles = 0, n_req = 0, rg;
    logic [31:0] cfg [3];
    logic [31:0] win [6];
    logic [44:0] expq [$];
    logic [44:0] ev;
    logic [5:0] last_d;

    sad_decoder DUT (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .req_valid, .req_addr, .req_write, .req_io, .req_smm_code,
        .req_dword, .req_src, .route_valid, .route_dest, .route_addr, .route_read_zero,
        .route_write_drop, .route_irq_msg, .target_ready_n);
    sad_src_model SRC (.clk, .req_valid, .req_addr, .req_write, .req_io, .req_smm_code,
        .req_dword, .req_src);

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic report_and_stop();
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic cmp(input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            rd = prdata;
            er = pslverr;
        end
        while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask

    function automatic logic [44:0] model(input sad_addr_t a, input sad_src_e s,
        input logic [3:0] f);
        logic hub, q, w;
        logic [5:0] d, vd, wn;
        logic [2:0] fl;
        sad_addr_t ra, lt;
        int sg;
        hub = s != SAD_SRC_PROC;
        w = f[3];
        q = !hub && cfg[0][2] && (cfg[0][3] || f[1]);
        lt = {4'h0, cfg[2][15:0], 16'h0};
        vd = cfg[0][8] ? 6'h04 : cfg[0][9] ? 6'h08 : cfg[0][10] ? 6'h10 : 6'h02;
        d = SAD_DEST_LEGACY;
        ra = a;
        fl = 3'h0;
        sg = (a < 36'hf0000) ? int'((a - 36'hc0000) >> 14) : 12;
        wn = 6'h0;
        for (int i = 5; i >= 0; i--)
            if (a[31:20] >= win[i][11:0] && a[31:20] <= win[i][27:16])
                wn = 6'h04 << (i / 2);
        if (f[2])
        begin
            if (a[15:0] inside {16'h3b4, 16'h3b5, 16'h3b8, 16'h3b9, 16'h3ba, 16'h3bf})
                d = cfg[0][0] ? SAD_DEST_LEGACY : vd;
        end
        else if (a >= 36'hfeda0000 && a <= 36'hfedbffff && cfg[0][2] && cfg[0][5] && (hub || q))
        begin
            d = SAD_DEST_MEM;
            ra = hub ? 36'h0 : a - 36'hfed00000;
            fl = hub ? {!w, w, 1'b0} : 3'h0;
        end
        else if (cfg[0][2] && cfg[0][4] && a < lt && a >= lt - (36'h20000 << cfg[0][7:6]))
        begin
            d = SAD_DEST_MEM;
            ra = q ? a : 36'h0;
            fl = q ? 3'h0 : {!w, w, 1'b0};
        end
        else if (a >= 36'ha0000 && a <= 36'hbffff)
            d = q ? 6'h01 : (cfg[0][0] && a <= 36'hb7fff && a >= 36'hb0000) ? 6'h02 : vd;
        else if (a >= 36'hc0000 && a <= 36'hfffff)
            d = (hub || cfg[1][2 * sg + w]) ? 6'h01 : 6'h02;
        else if (a >= 36'hf00000 && a <= 36'hffffff && cfg[0][1])
            d = SAD_DEST_LEGACY;
        else if (a >= 36'hfee00000 && a <= 36'hfeefffff)
        begin
            d = SAD_DEST_PROC;
            fl[0] = hub && w && f[0];
        end
        else if (!hub && a >= 36'hfec00000 && a <= 36'hfec82fff)
            d = a < 36'hfec80000 ? 6'h02 : 6'h04 << a[13:12];
        else if (a < 36'h100000000 && wn != 6'h0)
            d = wn;
        else
            d = (a < lt || a >= 36'h100000000) ? 6'h01 : 6'h02;
        return {fl, d, ra};
    endfunction

    task automatic send(input sad_addr_t a, input sad_src_e s, input logic [3:0] f);
        logic [44:0] e;
        e = model(a, s, f);
        expq.push_back(e);
        last_d = e[41:36];
        n_req++;
        SRC.issue(a, s, f);
    endtask

    always @(posedge clk or negedge rst_n)
        if (!rst_n)
            rv_d <= 1'b0;
        else
            rv_d <= req_valid;

    always @(negedge clk)
        if (rst_n)
        begin
            cmp(rv_d, route_valid);
            if (route_valid === 1'b1)
            begin
                ev = expq.pop_front();
                cmp(ev[44:42], {route_read_zero, route_write_drop, route_irq_msg});
                cmp(ev[42], !target_ready_n);
                cmp(ev[41:0], {route_dest, route_addr});
            end
        end

    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 11; i++)
        begin
            apb(1'b0, 12'(i * 4), 32'h0);
            cmp({er, rd}, {i == 10, i == 2 ? 32'h1000 : (i > 2 && i < 9) ? 32'hfff : i == 9 ? 32'h2 : 32'h0});
        end
        cfg = '{32'h0, 32'h0, 32'h1000};
        send(36'hf8000, SAD_SRC_PROC, 4'h0);
        send(36'ha8000, SAD_SRC_PROC, 4'h8);
        SRC.idle();
        apb(1'b1, 12'h028, 32'hffffffff);
        cmp(er, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            win[i] = {4'h0, 12'he0f + 12'(16 * i), 4'h0, 12'he00 + 12'(16 * i)};
            apb(1'b1, 12'h00c + 12'(4 * i), win[i]);
        end
        for (int k = 0; k < 12; k++)
        begin
            cfg[0] = $random(seed) & 32'h0ff;
            cfg[0][10:8] = 3'h1 << k[1:0];
            cfg[1] = (k % 4 == 3) ? 32'h3ffffff : $random(seed) & 32'h3ffffff;
            cfg[2] = 32'h1000 + ($random(seed) & 32'h7ff0);
            for (int j = 0; j < 3; j++)
                apb(1'b1, 12'(4 * j), cfg[j]);
            for (int j = 0; j < 3; j++)
            begin
                apb(1'b0, 12'(4 * j), 32'h0);
                cmp(rd, cfg[j]);
            end
            for (int n = 0; n < 60; n++)
            begin
                u = $random(seed);
                off = $random(seed);
                rg = u[7:0] % 11;
                s = sad_src_e'(u[31:29] % 5);
                if (rg == 1 && k % 4 != 3)
                    s = SAD_SRC_PROC;
                case (rg)
                    0: a = 36'ha0000 + off[16:0];
                    1: a = 36'hc0000 + off[17:0];
                    2: a = 36'hf00000 + off[19:0];
                    3: a = {4'h0, cfg[2][15:0], 16'h0} - 36'h100000 + off[20:0];
                    4: a = 36'hfeda0000 + off[16:0];
                    5: a = 36'hfee00000 + off[19:0];
                    6: a = off[31] ? 36'hfec80000 + off[13:0] : 36'hfec00000 + off[19:0];
                    7: a = 36'he0000000 + off[26:0];
                    8: a = {4'h0, off};
                    9: a = {2'h0, off[1:0] + 2'h1, off};
                    default: a = off[0] ? 36'h3b0 + off[4:1] : {20'h0, off[15:0]};
                endcase
                send(a, s, {u[8], rg == 10, s == SAD_SRC_PROC && u[9], u[10]});
                if (u[11])
                    SRC.idle();
            end
            SRC.idle();
        end
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        cfg = '{32'h0, 32'h0, 32'h1000};
        n_req = 0;
        for (int j = 0; j < 3; j++)
        begin
            apb(1'b0, 12'(4 * j), 32'h0);
            cmp(rd, cfg[j]);
        end
        send(36'h0, SAD_SRC_PROC, 4'h0);
        SRC.idle();
        apb(1'b0, 12'h024, 32'h0);
        cmp({rd[31:16], rd[5:0]}, {16'(n_req), last_d});
        report_and_stop();
    end
endmodule
